// file: verilog/buffer_transfer_port_dma.v
// buffer transfer port: scsi/audio handshake dma and cpu buffer reads
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`include "xfer_regs.vh"

// Overview of operation
// - enable clear stops at once, no done
// - counted end sets transfer done flag
// - counter ends zero, address one past last
// - host bus select high means scsi mode
// - scsi request answered by low acknowledge
// - scsi write acked when fifo not full
// - scsi read acked when fifo not empty
// - scsi ends by count or enable clear
// - cycle field selects three/four/five cycles
// - audio request acked when fifo not empty
// - host enable wins over audio enable
// - audio enable turns strobes into outputs
// - audio ends by count or enable clear
// - cpu reads use decoder counter, restricted
// - cpu enable fetches byte into read register
// - counter decrements per fifo write, drains
// - fifo holds two nine-bit entries
// - interrupt raised only when mask set
module buffer_transfer_port_dma (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  input  wire        host_bus_select,
  input  wire        scsi_req_in,
  output reg         scsi_ack_n,
  input  wire        audio_req_in,
  output reg         audio_ack_n,
  input  wire        wr_strobe_n_in,
  output reg         wr_strobe_n_out,
  output reg         wr_strobe_n_oe,
  input  wire        rd_strobe_n_in,
  output reg         rd_strobe_n_out,
  output reg         rd_strobe_n_oe,
  input  wire [7:0]  host_data_bus_in,
  output reg  [7:0]  host_data_bus_out,
  output reg         host_data_bus_oe,
  output reg  [15:0] buf_addr,
  output reg  [7:0]  buf_wdata,
  output reg         buf_we,
  output reg         buf_re,
  input  wire [7:0]  buf_rdata,
  input  wire        decoder_restrict,
  output reg         cpu_irq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ACK  = 2'h1;
  localparam ST_REL  = 2'h2;
  // pin synchronisers: stage one is read only by stage two
  reg [12:0] pin_meta;
  reg [12:0] pin_sync;
  reg        wr_prev;
  reg        host_xfer_enable;
  reg        count_term_enable;
  reg        xfer_direction;
  reg        audio_xfer_enable;
  reg        cpu_xfer_enable;
  reg        cpu_xfer_direction;
  reg [1:0]  cycle_len_field;
  reg        xfer_done_flag;
  reg [1:0]  irq_mask_reg;
  reg [15:0] xfer_byte_counter;
  reg [15:0] xfer_addr_counter;
  reg [15:0] decoder_addr_counter;
  reg [7:0]  cpu_buf_read_reg;
  reg        cpu_valid;
  reg        buf_own_cpu;
  reg        wr_pend;
  reg [7:0]  wr_addr;
  reg [31:0] rd_val;
  reg [1:0]  st;
  reg [2:0]  tmr;
  reg        took;
  wire [8:0] head;
  wire [1:0] level;
  wire       bus_sel_s  = pin_sync[12];
  wire       scsi_req_s = pin_sync[11];
  wire       audio_req_s = pin_sync[10];
  wire       wr_s       = pin_sync[9];
  wire       rd_s       = pin_sync[8];
  wire [7:0] data_s     = pin_sync[7:0];
  wire       wr_rise    = wr_s & ~wr_prev;
  wire addr_ok = hsel & hready & htrans[1];
  wire rd_sel  = addr_ok & ~hwrite;
  // scsi handshake only in scsi bus mode; audio needs no mode pin
  wire host_act = host_xfer_enable & bus_sel_s;
  wire ext_act  = host_act | audio_xfer_enable;
  wire to_ext   = audio_xfer_enable | ~xfer_direction;
  wire req_s    = audio_xfer_enable ? audio_req_s : scsi_req_s;
  wire empty    = (level == 2'h0);
  wire full     = (level == `FIFO_DEPTH);
  wire [2:0] cyc_len = cycle_len_field[1] ? `CYC_LEN_LONG :
                       (cycle_len_field[0] ? `CYC_LEN_MID :
                        `CYC_LEN_SHORT);
  wire dma_rd_pend = buf_re & ~buf_own_cpu;
  wire cpu_rd_pend = buf_re & buf_own_cpu;
  wire cnt_room    = ~count_term_enable | (xfer_byte_counter != 16'h0);
  wire cnt_issue   = ~count_term_enable |
                     (xfer_byte_counter > {15'h0, dma_rd_pend});
  wire ext_start = (st == ST_IDLE) & ext_act & req_s &
                   (to_ext ? ~empty : (~full & cnt_room));
  wire ext_push  = (st == ST_ACK) & ext_act & ~to_ext & wr_rise & ~took;
  wire ack_end   = (st == ST_ACK) & (tmr >= cyc_len) &
                   (to_ext | took | ext_push);
  wire ext_pop   = ack_end & to_ext;
  wire dma_wr_go = ext_act & ~to_ext & ~empty;
  wire dma_rd_go = ext_act & to_ext & cnt_issue &
                   (({1'b0, level} + {2'h0, dma_rd_pend}) < 3'h2);
  wire dma_ret   = dma_rd_pend & ext_act & to_ext;
  wire cpu_go    = ~dma_wr_go & ~dma_rd_go & cpu_xfer_enable &
                   ~cpu_xfer_direction & ~cpu_valid & ~cpu_rd_pend &
                   ~decoder_restrict;
  wire       fifo_push = ext_push | dma_ret;
  wire       fifo_pop  = ext_pop | dma_wr_go;
  wire       last_byte = count_term_enable &
                         (xfer_byte_counter == 16'h0001);
  wire [8:0] push_data = ext_push ? {last_byte, data_s} :
                                    {last_byte, buf_rdata};
  // done when the last counted byte leaves the fifo to its destination
  wire done_set  = ext_act & fifo_pop & head[8];
  wire wr_ctl = wr_pend & (wr_addr == `ADDR_CONTROL);
  wire wr_clr = wr_pend & (wr_addr == `ADDR_IRQ_CLEAR);
  xfer_fifo u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clear     (~ext_act),
    .push      (fifo_push),
    .push_data (push_data),
    .pop       (fifo_pop),
    .head      (head),
    .level     (level)
  );
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= 13'h0300;
      pin_sync <= 13'h0300;
      wr_prev  <= 1'b1;
    end else begin
      pin_meta <= {host_bus_select, scsi_req_in, audio_req_in,
                   wr_strobe_n_in, rd_strobe_n_in, host_data_bus_in};
      pin_sync <= pin_meta;
      wr_prev  <= wr_s;
    end
  end
  // register read data is prepared during the address phase
  always @* begin
    rd_val = 32'h0000_0000;
    case (haddr[7:0])
      `ADDR_CONTROL: begin
        rd_val[`CTL_HOST_EN]    = host_xfer_enable;
        rd_val[`CTL_COUNT_TERM] = count_term_enable;
        rd_val[`CTL_DIR]        = xfer_direction;
        rd_val[`CTL_AUDIO_EN]   = audio_xfer_enable;
        rd_val[`CTL_CPU_EN]     = cpu_xfer_enable;
        rd_val[`CTL_CPU_DIR]    = cpu_xfer_direction;
        rd_val[`CTL_CYC_HI:`CTL_CYC_LO] = cycle_len_field;
      end
      `ADDR_STATUS: begin
        rd_val[`STS_DONE]      = xfer_done_flag;
        rd_val[`STS_EMPTY]     = empty;
        rd_val[`STS_FULL]      = full;
        rd_val[`STS_CPU_VALID] = cpu_valid;
        rd_val[`STS_BUSY]      = (st != ST_IDLE);
        rd_val[`STS_BUS_SEL]   = bus_sel_s;
        rd_val[`STS_WR_PIN]    = wr_s;
        rd_val[`STS_RD_PIN]    = rd_s;
      end
      `ADDR_IRQ_MASK:   rd_val[1:0]  = irq_mask_reg;
      `ADDR_BYTE_COUNT: rd_val[15:0] = xfer_byte_counter;
      `ADDR_XFER_ADDR:  rd_val[15:0] = xfer_addr_counter;
      `ADDR_DEC_ADDR:   rd_val[15:0] = decoder_addr_counter;
      `ADDR_CPU_READ:   rd_val[7:0]  = cpu_buf_read_reg;
      default:          rd_val = 32'h0000_0000;
    endcase
  end
  // ahb-lite slave: zero wait states, always okay
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= rd_sel ? rd_val : 32'h0000_0000;
      wr_pend   <= addr_ok & hwrite;
      wr_addr   <= haddr[7:0];
    end
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_xfer_enable     <= 1'b0;
      count_term_enable    <= 1'b0;
      xfer_direction       <= 1'b0;
      audio_xfer_enable    <= 1'b0;
      cpu_xfer_enable      <= 1'b0;
      cpu_xfer_direction   <= 1'b0;
      cycle_len_field      <= 2'h0;
      xfer_done_flag       <= 1'b0;
      irq_mask_reg         <= 2'h0;
      xfer_byte_counter    <= `COUNT_RESET;
      xfer_addr_counter    <= `ADDR_RESET;
      decoder_addr_counter <= `ADDR_RESET;
      cpu_buf_read_reg     <= 8'h00;
      cpu_valid            <= 1'b0;
      buf_own_cpu          <= 1'b0;
      buf_addr             <= 16'h0000;
      buf_wdata            <= 8'h00;
      buf_we               <= 1'b0;
      buf_re               <= 1'b0;
      cpu_irq              <= 1'b0;
    end else begin
      if (wr_ctl) begin
        host_xfer_enable   <= hwdata[`CTL_HOST_EN];
        count_term_enable  <= hwdata[`CTL_COUNT_TERM];
        xfer_direction     <= hwdata[`CTL_DIR];
        audio_xfer_enable  <= hwdata[`CTL_AUDIO_EN] &
                              ~hwdata[`CTL_HOST_EN];
        cpu_xfer_enable    <= hwdata[`CTL_CPU_EN];
        cpu_xfer_direction <= hwdata[`CTL_CPU_DIR];
        cycle_len_field    <= hwdata[`CTL_CYC_HI:`CTL_CYC_LO];
      end
      if (wr_pend && wr_addr == `ADDR_IRQ_MASK)
        irq_mask_reg <= hwdata[1:0];
      // a completion in the clearing cycle is kept
      if (done_set)
        xfer_done_flag <= 1'b1;
      else if (wr_clr && hwdata[`IRQ_DONE_BIT])
        xfer_done_flag <= 1'b0;
      cpu_irq <= xfer_done_flag & irq_mask_reg[`IRQ_DONE_BIT];
      if (wr_pend && wr_addr == `ADDR_BYTE_COUNT)
        xfer_byte_counter <= hwdata[15:0];
      else if (fifo_push)
        xfer_byte_counter <= xfer_byte_counter - 16'h0001;
      if (wr_pend && wr_addr == `ADDR_XFER_ADDR)
        xfer_addr_counter <= hwdata[15:0];
      else if (dma_wr_go || dma_rd_go)
        xfer_addr_counter <= xfer_addr_counter + 16'h0001;
      if (wr_pend && wr_addr == `ADDR_DEC_ADDR)
        decoder_addr_counter <= hwdata[15:0];
      else if (cpu_go)
        decoder_addr_counter <= decoder_addr_counter + 16'h0001;
      buf_re      <= dma_rd_go | cpu_go;
      buf_we      <= dma_wr_go;
      buf_own_cpu <= cpu_go;
      buf_wdata   <= head[7:0];
      buf_addr    <= cpu_go ? decoder_addr_counter : xfer_addr_counter;
      // a new byte is fetched once software has read the last one
      if (cpu_rd_pend) begin
        cpu_buf_read_reg <= buf_rdata;
        cpu_valid        <= 1'b1;
      end else if (rd_sel && haddr[7:0] == `ADDR_CPU_READ) begin
        cpu_valid <= 1'b0;
      end
    end
  end
  // request/acknowledge handshake toward scsi or audio processor
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st                <= ST_IDLE;
      tmr               <= 3'h0;
      took              <= 1'b0;
      scsi_ack_n        <= 1'b1;
      audio_ack_n       <= 1'b1;
      host_data_bus_out <= 8'h00;
      host_data_bus_oe  <= 1'b0;
      wr_strobe_n_out   <= 1'b1;
      wr_strobe_n_oe    <= 1'b0;
      rd_strobe_n_out   <= 1'b1;
      rd_strobe_n_oe    <= 1'b0;
    end else begin
      wr_strobe_n_oe <= audio_xfer_enable;
      rd_strobe_n_oe <= audio_xfer_enable;
      wr_strobe_n_out <= 1'b1;
      if (!ext_act) begin
        // enable cleared: abandon the byte at once
        st               <= ST_IDLE;
        took             <= 1'b0;
        scsi_ack_n       <= 1'b1;
        audio_ack_n      <= 1'b1;
        host_data_bus_oe <= 1'b0;
        rd_strobe_n_out  <= 1'b1;
      end else begin
        case (st)
          ST_IDLE: begin
            if (ext_start) begin
              st                <= ST_ACK;
              tmr               <= 3'h1;
              took              <= 1'b0;
              scsi_ack_n        <= audio_xfer_enable;
              audio_ack_n       <= ~audio_xfer_enable;
              rd_strobe_n_out   <= ~audio_xfer_enable;
              host_data_bus_out <= head[7:0];
              host_data_bus_oe  <= to_ext;
            end
          end
          ST_ACK: begin
            if (tmr < cyc_len)
              tmr <= tmr + 3'h1;
            took <= took | ext_push;
            if (ack_end) begin
              st               <= ST_REL;
              scsi_ack_n       <= 1'b1;
              audio_ack_n      <= 1'b1;
              rd_strobe_n_out  <= 1'b1;
              host_data_bus_oe <= 1'b0;
            end
          end
          ST_REL: begin
            if (!req_s)
              st <= ST_IDLE;
          end
          default: st <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// file: include/xfer_regs.vh
// register map, field positions and timing counts of the transfer port
`ifndef XFER_REGS_VH
`define XFER_REGS_VH

// register byte offsets (low address byte)
`define ADDR_CONTROL      8'h00
`define ADDR_STATUS       8'h04
`define ADDR_IRQ_CLEAR    8'h08
`define ADDR_IRQ_MASK     8'h0c
`define ADDR_BYTE_COUNT   8'h10
`define ADDR_XFER_ADDR    8'h14
`define ADDR_DEC_ADDR     8'h18
`define ADDR_CPU_READ     8'h1c

// control register fields
`define CTL_HOST_EN       0
`define CTL_COUNT_TERM    1
`define CTL_DIR           2
`define CTL_AUDIO_EN      3
`define CTL_CPU_EN        4
`define CTL_CPU_DIR       5
`define CTL_CYC_LO        6
`define CTL_CYC_HI        7

// status register fields
`define STS_DONE          0
`define STS_EMPTY         1
`define STS_FULL          2
`define STS_CPU_VALID     3
`define STS_BUSY          4
`define STS_BUS_SEL       5
`define STS_WR_PIN        6
`define STS_RD_PIN        7

// completion bit in the clear and mask registers
`define IRQ_DONE_BIT      1

// reset values
`define CONTROL_RESET     8'h00
`define COUNT_RESET       16'h0000
`define ADDR_RESET        16'h0000

// strobe cycle lengths in clock cycles
`define CYC_LEN_SHORT     3'h3
`define CYC_LEN_MID       3'h4
`define CYC_LEN_LONG      3'h5

// fifo shape: two entries of nine bits, bit 8 marks the last byte
`define FIFO_WIDTH        9
`define FIFO_DEPTH        2'h2

`endif

// file: verilog/xfer_fifo.v
// two-entry transfer fifo, head entry held in a register
`include "xfer_regs.vh"

module xfer_fifo (
  input  wire                     hclk,
  input  wire                     hresetn,
  input  wire                     clear,
  input  wire                     push,
  input  wire [`FIFO_WIDTH-1:0]   push_data,
  input  wire                     pop,
  output reg  [`FIFO_WIDTH-1:0]   head,
  output reg  [1:0]               level
);

  reg [`FIFO_WIDTH-1:0] tail;

  // head always holds the oldest entry, so a pop shifts tail forward
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      head  <= {`FIFO_WIDTH{1'b0}};
      tail  <= {`FIFO_WIDTH{1'b0}};
      level <= 2'h0;
    end else if (clear) begin
      level <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (level == 2'h0)
            head <= push_data;
          else
            tail <= push_data;
          level <= level + 2'h1;
        end
        2'b01: begin
          head  <= tail;
          level <= level - 2'h1;
        end
        2'b11: begin
          if (level == 2'h1) begin
            head <= push_data;
          end else begin
            head <= tail;
            tail <= push_data;
          end
        end
        default: begin
          level <= level;
        end
      endcase
    end
  end

endmodule

// file: tb/btp_assertions.sv
// concurrent checks on the transfer port pins
module btp_checker (
  input wire       hclk,
  input wire       hresetn,
  input wire       hreadyout,
  input wire       hresp,
  input wire       scsi_req_in,
  input wire       scsi_ack_n,
  input wire       audio_ack_n,
  input wire       wr_strobe_n_oe,
  input wire       rd_strobe_n_oe,
  input wire       rd_strobe_n_out,
  input wire [7:0] host_data_bus_out,
  input wire       host_data_bus_oe,
  input wire       cpu_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence audio_low3;
    !audio_ack_n[*3];
  endsequence
  sequence scsi_high3;
    scsi_ack_n[*3];
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_reset_quiet: assert property ($rose(hresetn) |-> scsi_ack_n
    && audio_ack_n && !host_data_bus_oe && !cpu_irq)
    else $error("outputs active after reset");
  a_ack_exclusive: assert property (scsi_ack_n || audio_ack_n)
    else $error("both acknowledges low");
  a_scsi_cause: assert property ($fell(scsi_ack_n) |->
    $past(scsi_req_in, 3)) else $error("scsi ack without request");
  a_scsi_len: assert property ($fell(scsi_ack_n) |->
    !scsi_ack_n[*3]) else $error("scsi ack too short");
  a_audio_len: assert property ($fell(audio_ack_n) |->
    audio_low3 ##[1:3] audio_ack_n) else $error("audio ack length");
  a_ack_rest: assert property ($rose(scsi_ack_n) |-> scsi_high3)
    else $error("scsi ack reasserted too soon");
  a_oe_in_ack: assert property (host_data_bus_oe |->
    !scsi_ack_n || !audio_ack_n) else $error("bus driven outside ack");
  a_data_steady: assert property (host_data_bus_oe &&
    $past(host_data_bus_oe) |-> $stable(host_data_bus_out))
    else $error("bus data moved during ack");
  a_audio_pins: assert property (!audio_ack_n |->
    wr_strobe_n_oe && rd_strobe_n_oe) else $error("strobes not driven");
  a_rd_strobe: assert property (rd_strobe_n_out == audio_ack_n)
    else $error("read strobe does not follow audio ack");
endmodule
bind buffer_transfer_port_dma btp_checker btp_checker_inst (.hclk,
  .hresetn, .hreadyout, .hresp, .scsi_req_in, .scsi_ack_n, .audio_ack_n,
  .wr_strobe_n_oe, .rd_strobe_n_oe, .host_data_bus_out, .host_data_bus_oe,
  .cpu_irq, .rd_strobe_n_out);

// file: tb/far_side_model.sv
// requester model for the scsi and audio handshakes
module far_side_model (
  input  wire        hclk,
  input  wire        scsi_ack_n,
  input  wire        audio_ack_n,
  input  wire  [7:0] host_data_bus_out,
  output logic       scsi_req_in,
  output logic       audio_req_in,
  output logic       wr_strobe_n_in,
  output logic [7:0] data_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scsi_req_in = 1'b0;
    audio_req_in = 1'b0;
    wr_strobe_n_in = 1'b1;
    data_drv = 8'h5a;
  end
  task automatic xfer(input logic aud, input logic wr, input logic [7:0] d,
    output logic [7:0] got, output int len, output logic ok);
    int n;
    n = 0;
    len = 0;
    if (aud) audio_req_in <= 1'b1;
    else scsi_req_in <= 1'b1;
    do @(posedge hclk);
    while ((aud ? audio_ack_n : scsi_ack_n) && ++n < 40);
    got = host_data_bus_out;
    if (wr) begin
      data_drv <= d;
      wr_strobe_n_in <= 1'b0;
      repeat (2) @(posedge hclk);
      wr_strobe_n_in <= 1'b1;
    end
    while (!(aud ? audio_ack_n : scsi_ack_n) && len < 40) begin
      @(posedge hclk);
      len++;
    end
    ok = n < 40 && len < 40;
    // release, then leave the line showing a changed value
    scsi_req_in <= 1'b0;
    audio_req_in <= 1'b0;
    data_drv <= ~d;
    repeat (4) @(posedge hclk);
  endtask
endmodule

// file: tb/buffer_transfer_port_dma_test.sv
// self-checking bench of the buffer transfer port
module buffer_transfer_port_dma_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic        host_bus_select = 1'b1;
  logic        decoder_restrict = 1'b0;
  logic [7:0]  mem [256];
  logic [7:0]  a, got;
  logic [7:0]  dv [4];
  logic        ok;
  int          errors = 0;
  int          checked = 0;
  int          n, len;
  wire [31:0] hrdata;
  wire [15:0] buf_addr;
  wire [7:0]  buf_wdata, host_data_bus_out, drv;
  wire hreadyout, hresp, scsi_req_in, scsi_ack_n, audio_req_in, audio_ack_n;
  wire wr_strobe_n_out, wr_strobe_n_oe, rd_strobe_n_out, rd_strobe_n_oe;
  wire host_data_bus_oe, buf_we, buf_re, cpu_irq, wr_drv;
  wire wr_pin = wr_strobe_n_oe ? wr_strobe_n_out : wr_drv;
  wire rd_pin = rd_strobe_n_oe ? rd_strobe_n_out : 1'b1;
  wire [7:0] bus_in = host_data_bus_oe ? host_data_bus_out : drv;
  wire [7:0] buf_rdata = mem[buf_addr[7:0]];
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) if (buf_we) mem[buf_addr[7:0]] <= buf_wdata;
  buffer_transfer_port_dma buffer_transfer_port_dma_inst (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .host_bus_select,
    .scsi_req_in, .scsi_ack_n, .audio_req_in, .audio_ack_n,
    .wr_strobe_n_in(wr_pin), .wr_strobe_n_out, .wr_strobe_n_oe,
    .rd_strobe_n_in(rd_pin), .rd_strobe_n_out, .rd_strobe_n_oe,
    .host_data_bus_in(bus_in), .host_data_bus_out, .host_data_bus_oe,
    .buf_addr, .buf_wdata, .buf_we, .buf_re, .buf_rdata,
    .decoder_restrict, .cpu_irq);
  far_side_model far_side_model_inst (.hclk, .scsi_ack_n, .audio_ack_n,
    .host_data_bus_out, .scsi_req_in, .audio_req_in,
    .wr_strobe_n_in(wr_drv), .data_drv(drv));
  task finish_test;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task ahb(logic w, logic [7:0] ad, logic [31:0] d, output logic [31:0] q);
    int t;
    t = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++t < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++t < 20);
    q = hrdata;
    if (t >= 20) begin
      errors++;
      finish_test();
    end
  endtask
  task wr(logic [7:0] ad, logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, ad, d, q);
  endtask
  task rd(string nm, logic [7:0] ad, logic [31:0] e, logic [31:0] m);
    logic [31:0] q;
    ahb(1'b0, ad, 32'h0, q);
    chk(nm, q & m, e);
  endtask
  task px(logic aud, logic w, logic [7:0] d);
    far_side_model_inst.xfer(aud, w, d, got, len, ok);
    if (!ok) begin
      errors++;
      finish_test();
    end
  endtask
  // strobe cycle expected from the cycle field value
  function int elen(int k);
    return k == 0 ? 3 : k == 1 ? 4 : 5;
  endfunction
  task start(int cnt, logic [7:0] ctl);
    a = 8'($urandom % 200);
    wr(8'h10, 32'(cnt));
    wr(8'h14, {24'h0, a});
    wr(8'h00, {24'h0, ctl});
  endtask
  task stop;
    wr(8'h08, 32'h2);
    wr(8'h00, 32'h0);
    rd("done cleared", 8'h04, 32'h0, 32'h1);
  endtask
  initial begin
    void'($urandom(71));
    foreach (mem[i]) mem[i] = 8'($urandom);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    rd("control", 8'h00, 32'h0, 32'hffffffff);
    rd("status", 8'h04, 32'h22, 32'h3f);
    rd("unmapped", 8'h40, 32'h0, 32'hffffffff);
    wr(8'h0c, 32'h2);
    for (int k = 0; k < 4; k++) begin
      n = 1 + $urandom % 3;
      start(n, {2'(k), 6'h0} | (k[0] ? 8'h0a : 8'h03));
      for (int i = 0; i < n; i++) begin
        px(k[0], 1'b0, 8'h0);
        chk("byte out", 32'(got), 32'(mem[a + 8'(i)]));
        chk("ack length", 32'(len), 32'(elen(k)));
      end
      if (k[0]) chk("strobe oe", 32'(wr_strobe_n_oe), 32'h1);
      chk("irq", 32'(cpu_irq), 32'h1);
      rd("done", 8'h04, 32'h1, 32'h1);
      rd("count", 8'h10, 32'h0, 32'hffff);
      rd("addr", 8'h14, 32'(a) + 32'(n), 32'hffff);
      stop();
      chk("irq off", 32'(cpu_irq), 32'h0);
      $display("test counted read %0d ends", k);
    end
    n = 2 + $urandom % 3;
    start(n, 8'h07);
    for (int i = 0; i < n; i++) begin
      dv[i] = 8'($urandom);
      px(1'b0, 1'b1, dv[i]);
    end
    repeat (4) @(posedge hclk);
    for (int i = 0; i < n; i++)
      chk("stored", 32'(mem[a + 8'(i)]), 32'(dv[i]));
    rd("write done", 8'h04, 32'h1, 32'h1);
    rd("write count", 8'h10, 32'h0, 32'hffff);
    stop();
    $display("test counted write ends");
    start(5, 8'h03);
    px(1'b0, 1'b0, 8'h0);
    wr(8'h00, 32'h0);
    repeat (3) @(posedge hclk);
    rd("no done", 8'h04, 32'h0, 32'h1);
    chk("ack idle", 32'(scsi_ack_n), 32'h1);
    wr(8'h00, 32'h09);
    rd("host wins", 8'h00, 32'h1, 32'h9);
    wr(8'h00, 32'h0);
    host_bus_select <= 1'b0;
    start(1, 8'h03);
    repeat (4) @(posedge hclk);
    rd("mode pin", 8'h04, 32'h0, 32'h20);
    far_side_model_inst.xfer(1'b0, 1'b0, 8'h0, got, len, ok);
    chk("no ack", 32'(ok), 32'h0);
    wr(8'h00, 32'h0);
    host_bus_select <= 1'b1;
    $display("test abort and priority ends");
    a = 8'($urandom % 200);
    wr(8'h18, {24'h0, a});
    decoder_restrict <= 1'b1;
    wr(8'h00, 32'h10);
    repeat (4) @(posedge hclk);
    rd("cpu blocked", 8'h04, 32'h0, 32'h8);
    decoder_restrict <= 1'b0;
    repeat (4) @(posedge hclk);
    rd("cpu valid", 8'h04, 32'h8, 32'h8);
    rd("cpu byte", 8'h1c, 32'(mem[a]), 32'hff);
    wr(8'h00, 32'h0);
    $display("test cpu read ends");
    finish_test();
  end
endmodule
